// [hdl/serial_port_defs.svh]
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// Register addresses on the special-function bus
`define SCS_ADDR 8'h98
`define SDB_ADDR 8'h99

// Field positions inside serial_control_status
`define SCS_MODE_BIT 3'h7
`define SCS_UNUSED_BIT 3'h6
`define SCS_MCE_BIT 3'h5
`define SCS_REN_BIT 3'h4
`define SCS_TB8_BIT 3'h3
`define SCS_RB8_BIT 3'h2
`define SCS_TI_BIT 3'h1
`define SCS_RI_BIT 3'h0

// Reset values
`define SCS_RESET 8'h40
`define SDB_RESET 8'h00

// Index of the last data bit, eight bits sent LSB first
`define LAST_DATA_BIT 3'h7

`endif

// [hdl/serial_port_pkg.sv]
package serial_port_pkg;

    // Gray codes along idle, start, data, ninth, stop
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_NINTH = 3'h2,
        TX_STOP = 3'h6
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_NINTH = 3'h2,
        RX_STOP = 3'h6
    } rx_state_t;

endpackage

// [hdl/rx_link_if.sv]
`timescale 1ns/1ps
interface rx_link_if;
    logic tick;
    logic pinIn;
    logic enable;
    logic mode9;
    logic reload;
    logic frameDone;
    logic [7:0] frameData;
    logic frameNinth;
    logic frameStop;

    modport engine (
        input tick,
        input pinIn,
        input enable,
        input mode9,
        output reload,
        output frameDone,
        output frameData,
        output frameNinth,
        output frameStop
    );

    modport host (
        output tick,
        output pinIn,
        output enable,
        output mode9,
        input reload,
        input frameDone,
        input frameData,
        input frameNinth,
        input frameStop
    );
endinterface

// [hdl/serial_rx_engine.sv]
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module serial_rx_engine (
    input wire logic clk_sys,
    input wire logic rst_n,
    rx_link_if.engine lnk
);
    serial_port_pkg::rx_state_t state_reg, state_next;
    logic skip_reg, skip_next;
    logic [2:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic ninth_reg, ninth_next;
    logic stop_reg, stop_next;
    logic done_reg, done_next;
    logic pinPrev_reg;
    logic reload;

    // Frame walk; each bit spans two ticks, first sample half a bit in
    always_comb begin
        state_next = state_reg;
        skip_next = skip_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        ninth_next = ninth_reg;
        stop_next = stop_reg;
        done_next = 1'b0;
        reload = 1'b0;
        case (state_reg)
            serial_port_pkg::RX_IDLE: begin
                if (lnk.enable && pinPrev_reg && !lnk.pinIn) begin
                    reload = 1'b1;
                    skip_next = 1'b0;
                    state_next = serial_port_pkg::RX_START;
                end
            end
            default: begin
                if (!lnk.enable) begin
                    // Dropping enable abandons a frame in flight
                    state_next = serial_port_pkg::RX_IDLE;
                end else if (lnk.tick && skip_reg) begin
                    skip_next = 1'b0;
                end else if (lnk.tick) begin
                    skip_next = 1'b1;
                    case (state_reg)
                        serial_port_pkg::RX_START: begin
                            // A glitch that is high at centre is no start
                            bitCnt_next = 3'h0;
                            state_next = lnk.pinIn ?
                                serial_port_pkg::RX_IDLE :
                                serial_port_pkg::RX_DATA;
                        end
                        serial_port_pkg::RX_DATA: begin
                            shift_next = {lnk.pinIn, shift_reg[7:1]};
                            bitCnt_next = bitCnt_reg + 3'h1;
                            if (bitCnt_reg == `LAST_DATA_BIT) begin
                                state_next = lnk.mode9 ?
                                    serial_port_pkg::RX_NINTH :
                                    serial_port_pkg::RX_STOP;
                            end
                        end
                        serial_port_pkg::RX_NINTH: begin
                            ninth_next = lnk.pinIn;
                            state_next = serial_port_pkg::RX_STOP;
                        end
                        serial_port_pkg::RX_STOP: begin
                            stop_next = lnk.pinIn;
                            done_next = 1'b1;
                            state_next = serial_port_pkg::RX_IDLE;
                        end
                        default: begin
                            state_next = serial_port_pkg::RX_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= serial_port_pkg::RX_IDLE;
            skip_reg <= 1'b0;
            bitCnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            ninth_reg <= 1'b0;
            stop_reg <= 1'b0;
            done_reg <= 1'b0;
            pinPrev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            skip_reg <= skip_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            ninth_reg <= ninth_next;
            stop_reg <= stop_next;
            done_reg <= done_next;
            pinPrev_reg <= lnk.pinIn;
        end
    end

    assign lnk.reload = reload;
    assign lnk.frameDone = done_reg;
    assign lnk.frameData = shift_reg;
    assign lnk.frameNinth = ninth_reg;
    assign lnk.frameStop = stop_reg;
endmodule // serial_rx_engine

// [hdl/async_serial_port.sv]
// How it works
// - Ninth bit one marks address frames
// - Nine-bit enable: accept only ninth-bit-one frames
// - Eight-bit enable: accept only valid stop
// - Top control bit picks eight/nine bits
// - Bit six reads one, ignores writes
// - Receive only while receive enable set
// - Nine-bit mode sends software ninth bit
// - Status captures stop or ninth bit
// - Transmit flag set at stop start
// - Receive flag set one clock after stop sample
// - Only software clears done flags
// - Set flags request interrupt when enabled
// - Buffer write loads and starts transmit
// - Buffer read returns receive latch
// - Nine-bit frame is eleven bit times
// - Eight-bit frame is ten bit times
// - Load only when flag clear, check passes
// - Bit rate is half overflow rate
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module async_serial_port (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    output logic [7:0] sfrRdData,
    input wire logic bitWrEn,
    input wire logic [2:0] bitIdx,
    input wire logic bitWrVal,
    input wire logic intEnable,
    output logic intReq,
    input wire logic txTick,
    input wire logic rxTick,
    output logic rxTimerReload,
    input wire logic serialInPin,
    output logic serialOutPin
);
    rx_link_if rxLink();

    logic mode_reg, mode_next;
    logic mce_reg, mce_next;
    logic ren_reg, ren_next;
    logic tb8_reg, tb8_next;
    logic rb8_reg, rb8_next;
    logic ti_reg, ti_next;
    logic ri_reg, ri_next;
    logic [7:0] rxLatch_reg, rxLatch_next;
    logic [7:0] rdData_reg, rdData_next;
    logic [7:0] ctrlCur;
    logic [7:0] ctrlSw;
    logic ctrlHit;
    logic bufWrite;
    logic rxAccept;
    logic rxCheck;
    logic txSet;

    serial_port_pkg::tx_state_t txState_reg, txState_next;
    logic txSkip_reg, txSkip_next;
    logic [2:0] txCnt_reg, txCnt_next;
    logic [7:0] txShift_reg, txShift_next;
    logic txNinth_reg, txNinth_next;
    logic txOut_reg, txOut_next;

    // Receive engine sits on the same clock
    assign rxLink.tick = rxTick;
    assign rxLink.pinIn = serialInPin;
    assign rxLink.enable = ren_reg;
    assign rxLink.mode9 = mode_reg;
    assign rxTimerReload = rxLink.reload;

    serial_rx_engine rxEngine (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .lnk(rxLink.engine)
    );

    assign ctrlCur = {mode_reg, 1'b1, mce_reg, ren_reg,
                      tb8_reg, rb8_reg, ti_reg, ri_reg};
    assign ctrlHit = (sfrAddr == `SCS_ADDR);
    assign bufWrite = sfrWrEn && (sfrAddr == `SDB_ADDR);

    always_comb begin
        ctrlSw = ctrlCur;
        if (ctrlHit && sfrWrEn) begin
            ctrlSw = sfrWrData;
        end else if (ctrlHit && bitWrEn) begin
            ctrlSw[bitIdx] = bitWrVal;
        end
    end

    assign rxCheck = !mce_reg ||
        (mode_reg ? rxLink.frameNinth : rxLink.frameStop);
    assign rxAccept = rxLink.frameDone && !ri_reg && rxCheck;

    // Control, latch and read path next values
    always_comb begin
        mode_next = ctrlSw[`SCS_MODE_BIT];
        mce_next = ctrlSw[`SCS_MCE_BIT];
        ren_next = ctrlSw[`SCS_REN_BIT];
        tb8_next = ctrlSw[`SCS_TB8_BIT];
        rb8_next = ctrlSw[`SCS_RB8_BIT];
        rxLatch_next = rxLatch_reg;
        // hardware only sets; set beats a same-cycle clear
        ti_next = ctrlSw[`SCS_TI_BIT] | txSet;
        ri_next = ctrlSw[`SCS_RI_BIT] | rxAccept;
        if (rxAccept) begin
            rb8_next = mode_reg ? rxLink.frameNinth : rxLink.frameStop;
            rxLatch_next = rxLink.frameData;
        end
        rdData_next = rdData_reg;
        if (sfrRdEn) begin
            if (ctrlHit) begin
                rdData_next = ctrlCur;
            end else if (sfrAddr == `SDB_ADDR) begin
                rdData_next = rxLatch_reg;
            end else begin
                rdData_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= 1'b0;
            mce_reg <= 1'b0;
            ren_reg <= 1'b0;
            tb8_reg <= 1'b0;
            rb8_reg <= 1'b0;
            ti_reg <= 1'b0;
            ri_reg <= 1'b0;
            rxLatch_reg <= `SDB_RESET;
            rdData_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            mce_reg <= mce_next;
            ren_reg <= ren_next;
            tb8_reg <= tb8_next;
            rb8_reg <= rb8_next;
            ti_reg <= ti_next;
            ri_reg <= ri_next;
            rxLatch_reg <= rxLatch_next;
            rdData_reg <= rdData_next;
        end
    end

    // Transmitter; a write mid-frame restarts with the new byte
    always_comb begin
        txState_next = txState_reg;
        txSkip_next = txSkip_reg;
        txCnt_next = txCnt_reg;
        txShift_next = txShift_reg;
        txNinth_next = txNinth_reg;
        txOut_next = txOut_reg;
        txSet = 1'b0;
        if (bufWrite) begin
            txShift_next = sfrWrData;
            txNinth_next = tb8_reg;
            txOut_next = 1'b0;
            txSkip_next = 1'b0;
            txState_next = serial_port_pkg::TX_START;
        end else if (txTick && !txSkip_reg &&
                     txState_reg != serial_port_pkg::TX_IDLE) begin
            txSkip_next = 1'b1;
        end else if (txTick && txSkip_reg) begin
            txSkip_next = 1'b0;
            case (txState_reg)
                serial_port_pkg::TX_START: begin
                    txCnt_next = 3'h0;
                    txOut_next = txShift_reg[0];
                    txState_next = serial_port_pkg::TX_DATA;
                end
                serial_port_pkg::TX_DATA: begin
                    // LSB first, then ninth or stop
                    txCnt_next = txCnt_reg + 3'h1;
                    txShift_next = {1'b0, txShift_reg[7:1]};
                    txOut_next = txShift_reg[1];
                    if (txCnt_reg == `LAST_DATA_BIT) begin
                        if (mode_reg) begin
                            txOut_next = txNinth_reg;
                            txState_next = serial_port_pkg::TX_NINTH;
                        end else begin
                            txOut_next = 1'b1;
                            txSet = 1'b1;
                            txState_next = serial_port_pkg::TX_STOP;
                        end
                    end
                end
                serial_port_pkg::TX_NINTH: begin
                    txOut_next = 1'b1;
                    txSet = 1'b1;
                    txState_next = serial_port_pkg::TX_STOP;
                end
                serial_port_pkg::TX_STOP: begin
                    txState_next = serial_port_pkg::TX_IDLE;
                end
                default: begin
                    txOut_next = 1'b1;
                    txState_next = serial_port_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txState_reg <= serial_port_pkg::TX_IDLE;
            txSkip_reg <= 1'b0;
            txCnt_reg <= 3'h0;
            txShift_reg <= 8'h00;
            txNinth_reg <= 1'b0;
            txOut_reg <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            txSkip_reg <= txSkip_next;
            txCnt_reg <= txCnt_next;
            txShift_reg <= txShift_next;
            txNinth_reg <= txNinth_next;
            txOut_reg <= txOut_next;
        end
    end

    assign serialOutPin = txOut_reg;
    assign sfrRdData = rdData_reg;
    assign intReq = intEnable && (ti_reg || ri_reg);
endmodule // async_serial_port

// [testbench/async_serial_port_checker.sv]
`timescale 1ns/1ps
module async_serial_port_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrRdData,
    input wire logic bitWrEn,
    input wire logic [2:0] bitIdx,
    input wire logic bitWrVal,
    input wire logic intEnable,
    input wire logic intReq,
    input wire logic txTick,
    input wire logic rxTick,
    input wire logic rxTimerReload,
    input wire logic serialInPin,
    input wire logic serialOutPin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic [7:0] shadow_reg;

    // Software-only control bits; bit writes land only at the control byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shadow_reg <= 8'h40;
        end else if (sfrWrEn && sfrAddr == 8'h98) begin
            shadow_reg <= sfrWrData;
        end else if (bitWrEn && sfrAddr == 8'h98) begin
            shadow_reg[bitIdx] <= bitWrVal;
        end
    end

    chk_int_gate: assert property (
        !intEnable |-> !intReq) else $error("request while disabled");
    chk_flag_hold: assert property (
        intReq && !sfrWrEn && !bitWrEn |=> intReq || !intEnable)
        else $error("done flag dropped by hardware");
    chk_unmapped_read: assert property (
        sfrRdEn && sfrAddr != 8'h98 && sfrAddr != 8'h99 |=>
        sfrRdData == 8'h00) else $error("unmapped read not zero");
    chk_unused_high: assert property (
        sfrRdEn && sfrAddr == 8'h98 |=> sfrRdData[6])
        else $error("unused bit read low");
    chk_soft_bits: assert property (
        sfrRdEn && sfrAddr == 8'h98 && !sfrWrEn && !bitWrEn |=>
        (sfrRdData & 8'hb8) == (shadow_reg & 8'hb8))
        else $error("control bits differ from written");
    chk_read_hold: assert property (
        !sfrRdEn |=> $stable(sfrRdData)) else $error("read data moved");
    chk_tx_start: assert property (
        sfrWrEn && sfrAddr == 8'h99 |=> !serialOutPin)
        else $error("no start bit after buffer write");
    chk_tx_pace: assert property (
        $changed(serialOutPin) |->
        $past(txTick) || ($past(sfrWrEn) && $past(sfrAddr) == 8'h99))
        else $error("line changed without tick");
    chk_reload_edge: assert property (
        rxTimerReload |-> $fell(serialInPin))
        else $error("reload without falling edge");

    cover property (rxTimerReload);
    cover property (sfrWrEn && sfrAddr == 8'h99);
    cover property ($rose(intReq));
endmodule // async_serial_port_checker

bind async_serial_port async_serial_port_checker chk (
    .clk_sys, .rst_n, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData,
    .bitWrEn, .bitIdx, .bitWrVal, .intEnable, .intReq, .txTick, .rxTick,
    .rxTimerReload, .serialInPin, .serialOutPin);

// [testbench/serial_far_end.sv]
`timescale 1ns/1ps
module serial_far_end #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk_sys,
    input wire logic nineBits,
    input wire logic lineIn,
    output logic lineOut,
    output logic [7:0] gotData,
    output logic gotNinth,
    output logic gotStop,
    output int gotCount
);
    logic [9:0] bits;

    initial begin
        lineOut = 1'b1;
        gotCount = 0;
    end

    // start, data LSB first, ninth, stop
    task automatic send(input logic [7:0] d, input logic nine,
                        input logic b9, input logic stopVal);
        logic [10:0] frame;
        frame = {stopVal, b9, d, 1'b0};
        @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || nine) begin
                lineOut <= frame[i];
                repeat (BIT_CYCLES) @(posedge clk_sys);
            end
        end
        lineOut <= 1'b1; // Idle high, pulled up
        repeat (BIT_CYCLES) @(posedge clk_sys);
    endtask

    // centre sampling off the falling start edge
    initial begin
        forever begin
            @(negedge lineIn);
            repeat (BIT_CYCLES / 2) @(negedge clk_sys);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CYCLES) @(negedge clk_sys);
                bits[i] = lineIn;
                if (i == 8 + nineBits) break;
            end
            gotData = bits[7:0];
            gotNinth = bits[8];
            gotStop = nineBits ? bits[9] : bits[8];
            gotCount++;
        end
    end
endmodule // serial_far_end

// [testbench/async_serial_port_tb_top.sv]
`timescale 1ns/1ps
module async_serial_port_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWrData = 8'h00;
    logic sfrWrEn = 1'b0;
    logic sfrRdEn = 1'b0;
    logic [7:0] sfrRdData;
    logic bitWrEn = 1'b0;
    logic [2:0] bitIdx = 3'h0;
    logic bitWrVal = 1'b0;
    logic intEnable = 1'b1;
    logic intReq;
    logic txTick = 1'b0;
    logic rxTick = 1'b0;
    logic rxTimerReload;
    logic serialInPin;
    logic serialOutPin;
    logic nineBits = 1'b0;
    logic [2:0] txCnt = 3'h0;
    logic [2:0] rxCnt = 3'h0;
    logic [7:0] gotData;
    logic gotNinth;
    logic gotStop;
    int gotCount;
    logic [7:0] expBuf = 8'h00;
    int numErrors = 0;
    int nChecks = 0;

    always #4 clk_sys = ~clk_sys;

    async_serial_port uut (.clk_sys, .rst_n, .sfrAddr, .sfrWrData, .sfrWrEn,
        .sfrRdEn, .sfrRdData, .bitWrEn, .bitIdx, .bitWrVal, .intEnable,
        .intReq, .txTick, .rxTick, .rxTimerReload, .serialInPin,
        .serialOutPin);
    serial_far_end #(.BIT_CYCLES(16)) farEnd (.clk_sys, .nineBits,
        .lineIn(serialOutPin), .lineOut(serialInPin), .gotData, .gotNinth,
        .gotStop, .gotCount);

    // Overflow ticks, two per bit; RX timer restarts on a start edge
    always @(posedge clk_sys) begin
        txCnt <= txCnt + 3'h1;
        txTick <= (txCnt == 3'h7);
        rxCnt <= rxTimerReload ? 3'h0 : rxCnt + 3'h1;
        rxTick <= !rxTimerReload && rxCnt == 3'h6;
    end

    task automatic check8(input string name, input logic [7:0] exp,
                          input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrEn <= 1'b1;
        @(posedge clk_sys);
        sfrWrEn <= 1'b0;
    endtask

    task automatic bitWrite(input logic [2:0] i, input logic v);
        @(posedge clk_sys);
        sfrAddr <= 8'h98;
        bitIdx <= i;
        bitWrVal <= v;
        bitWrEn <= 1'b1;
        @(posedge clk_sys);
        bitWrEn <= 1'b0;
    endtask

    // Read data is registered, so look after the taking edge settles
    task automatic expectReg(input string name, input logic [7:0] a,
                             input logic [7:0] e);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge clk_sys);
        sfrRdEn <= 1'b0;
        @(negedge clk_sys);
        check8(name, e, sfrRdData);
    endtask

    // One transmitted frame, judged by the far end
    task automatic sendOut(input logic [7:0] d, input logic [7:0] ctrl);
        int n;
        int k;
        n = gotCount;
        k = 0;
        regWrite(8'h98, ctrl);
        nineBits <= ctrl[7];
        regWrite(8'h99, d);
        while (intReq !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        // Limit out shows up as a missing flag
        check8("done flag seen", 8'h01, {7'h0, intReq});
        check8("line at done flag", 8'h01, {7'h0, serialOutPin});
        while (gotCount == n && k < 800) begin
            @(negedge clk_sys);
            k++;
        end
        // Limit out shows up as a missing frame
        check8("frame seen", 8'h01, {7'h0, gotCount != n});
        check8("sent data", d, gotData);
        check8("sent ninth", {7'h0, ctrl[7] ? ctrl[3] : 1'b1},
               {7'h0, gotNinth});
        check8("sent stop", 8'h01, {7'h0, gotStop});
        repeat (40) @(negedge clk_sys);
        check8("done flag kept", 8'h01, {7'h0, intReq});
    endtask

    // One received frame and the resulting register state
    task automatic recvCase(input logic [7:0] ctrl, input logic [7:0] d,
                            input logic b9, input logic stopVal,
                            input logic acc);
        logic [7:0] e;
        regWrite(8'h98, ctrl);
        farEnd.send(d, ctrl[7], b9, stopVal);
        e = ctrl | 8'h40;
        if (acc) begin
            expBuf = d;
            e = e | 8'h01 | {5'h0, ctrl[7] ? b9 : stopVal, 2'h0};
        end
        expectReg("control after frame", 8'h98, e);
        expectReg("receive latch", 8'h99, expBuf);
    endtask

    task automatic finalReport();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the eleven frames of the run
    initial begin
        repeat (60000) @(posedge clk_sys);
        numErrors++;
        finalReport();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        expectReg("control reset", 8'h98, 8'h40);
        expectReg("buffer reset", 8'h99, 8'h00);
        regWrite(8'ha0, 8'hff);
        expectReg("unmapped read", 8'ha0, 8'h00);
        regWrite(8'h98, 8'h00);
        expectReg("unused bit", 8'h98, 8'h40);
        regWrite(8'h98, 8'hbf);
        expectReg("all bits set", 8'h98, 8'hff);
        check8("request enabled", 8'h01, {7'h0, intReq});
        @(posedge clk_sys);
        intEnable <= 1'b0;
        @(negedge clk_sys);
        check8("request masked", 8'h00, {7'h0, intReq});
        @(posedge clk_sys);
        intEnable <= 1'b1;
        regWrite(8'h98, 8'h00);
        bitWrite(3'h4, 1'b1);
        bitWrite(3'h6, 1'b0);
        expectReg("bit access", 8'h98, 8'h50);
        sendOut(8'ha5, 8'h00);
        sendOut(8'h3c, 8'h88);
        sendOut(8'hc6, 8'h80);
        recvCase(8'h10, 8'h5a, 1'b0, 1'b0, 1'b1);
        recvCase(8'h30, 8'h11, 1'b0, 1'b0, 1'b0);
        recvCase(8'h30, 8'hc3, 1'b0, 1'b1, 1'b1);
        recvCase(8'hb0, 8'h22, 1'b0, 1'b1, 1'b0);
        recvCase(8'hb0, 8'h96, 1'b1, 1'b0, 1'b1);
        recvCase(8'h90, 8'h44, 1'b0, 1'b1, 1'b1);
        recvCase(8'h80, 8'h77, 1'b1, 1'b1, 1'b0);
        recvCase(8'h11, 8'h88, 1'b0, 1'b1, 1'b0);
        finalReport();
    end
endmodule // async_serial_port_tb_top
